// File: inc/hpc_pkg.sv
// Purpose: Shared constants for the hub port power and clock configuration block.
// Assumes: 32-bit register port with byte addresses on word boundaries.
// Notes:   Offsets, field positions, reset values and timing counts live here only.
package hpc_pkg;

   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] HPC_OFF_CTRL   = 8'h00;
   localparam logic [7:0] HPC_OFF_FAULT  = 8'h04;
   localparam logic [7:0] HPC_OFF_STATUS = 8'h08;
   localparam logic [7:0] HPC_OFF_DESC   = 8'h0c;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int HPC_CTRL_REQ_LSB   = 0;
   localparam int HPC_CTRL_SHARED    = 3;
   localparam int HPC_CTRL_SUSPEND   = 4;
   localparam int HPC_ST_EN_LSB      = 0;
   localparam int HPC_ST_OC_LSB      = 3;
   localparam int HPC_ST_SHARED      = 6;
   localparam int HPC_ST_BUS_POWER_SELECT      = 7;
   localparam int HPC_ST_CLKMODE     = 8;
   localparam int HPC_ST_SLEW_LSB    = 9;
   localparam int HPC_DESC_COMPOUND  = 8;
   localparam int HPC_DESC_THREE     = 9;
   localparam int HPC_COMPOUND_BIT   = 2;

   // ----------------------------------------------------------------
   // Reset values and descriptor codes
   // ----------------------------------------------------------------
   localparam logic [2:0] HPC_REQ_RST      = 3'h0;
   localparam logic       HPC_SHARED_RST   = 1'b0;
   localparam logic [7:0] HPC_REM_NONE     = 8'h00;
   localparam logic [7:0] HPC_REM_P1       = 8'h02;
   localparam logic [7:0] HPC_REM_P12      = 8'h06;
   localparam logic [7:0] HPC_REM_P123     = 8'h0e;

   // ----------------------------------------------------------------
   // Clock multiplier and timing
   // ----------------------------------------------------------------
   localparam int HPC_REF_MHZ       = 6;
   localparam int HPC_CORE_MHZ      = 48;
   localparam logic [3:0] HPC_MULT_RATIO = 4'(HPC_CORE_MHZ / HPC_REF_MHZ);
   localparam int HPC_CLK_PERIOD_PS = 4000;
   localparam int HPC_OC_FILTER_NS  = 100;
   localparam int HPC_OC_FILTER_CYC = (HPC_OC_FILTER_NS * 1000 + HPC_CLK_PERIOD_PS - 1) / HPC_CLK_PERIOD_PS;

endpackage

// File: core/hpc_port_power.sv
// Purpose: Downstream port power control, clock source selection and strap decode for a small hub.
// Assumes: Pins arrive asynchronously; port speed flags come from logic on the same clock.
// Notes:   Overcurrent inputs are active low; power enables are active high.
//
// Notes on behaviour
// - A qualified overcurrent turns off the power enable of every port that this input covers.
// - In shared mode all active power enables move together and the overcurrent input of any active port is honoured.
// - In individual mode each port's enable and overcurrent input act for that port only.
// - Bus or self power and shared or individual control combine into four supported modes.
// - With the clock mode input low the core clock is taken from the clock multiplier.
// - With the clock mode input high the core runs from the oscillator input and the multiplier and oscillator cell power down.
// - In reference mode the multiplier makes the 48 MHz core clock from a 6 MHz input.
// - Each port sets its slew rate from the speed of the attached device.
// - The port count strap low makes a three-port hub, high a two-port hub.
// - Fixed port strap 00, 01 and 10 give removable fields 00h, 02h and 06h.
// - Fixed port strap 11 gives 06h for two ports and 0Eh for three ports.
// - The compound bit of the hub characteristics is 0 for strap 00 and 1 otherwise.
// - With the memory interface disabled the shared select comes from the memory data pin.
//
// Strobed register access and the address map were left to the implementer.
`timescale 1ns/1ps
module hpc_port_power
   import hpc_pkg::*;
#(
   parameter int NPORTS = 3
) (
   // Clock and reset
   input  wire logic              clock,
   input  wire logic              rst_n,
   // Register port
   input  wire logic [7:0]        reg_addr,
   input  wire logic [31:0]       reg_wdata,
   input  wire logic              reg_write,
   input  wire logic              reg_read,
   output logic      [31:0]       reg_rdata,
   // Power switch pins
   input  wire logic [NPORTS-1:0] overcurrent_in_n,
   output logic      [NPORTS-1:0] port_power_enable,
   // Configuration pins
   input  wire logic              bus_power_select,
   input  wire logic              clock_mode,
   input  wire logic              port_count_strap,
   input  wire logic [1:0]        fixed_port_strap,
   input  wire logic              ext_memory_disable,
   input  wire logic              prom_data_line,
   // Port speed from the transceivers
   input  wire logic [NPORTS-1:0] port_low_speed,
   output logic      [NPORTS-1:0] port_slew_slow,
   // Clock control
   output logic                   core_clk_from_mult,
   output logic                   clock_multiplier_pd,
   output logic                   osc_cell_pd,
   output logic      [3:0]        clock_multiplier_ratio,
   output logic                   suspend_status,
   // Descriptor fields
   output logic      [7:0]        device_removable,
   output logic                   hub_compound,
   output logic                   hub_three_port
);
   // ----------------------------------------------------------------
   // Decode helpers
   // ----------------------------------------------------------------
   function automatic logic [7:0] removable_field(input logic [1:0] fixed, input logic two_port);
      case (fixed)
         2'h0:    removable_field = HPC_REM_NONE;
         2'h1:    removable_field = HPC_REM_P1;
         2'h2:    removable_field = HPC_REM_P12;
         default: removable_field = two_port ? HPC_REM_P12 : HPC_REM_P123;
      endcase
   endfunction

   function automatic logic [NPORTS-1:0] active_ports(input logic three);
      active_ports = '1;
      if (!three && NPORTS > 2) begin
         active_ports[NPORTS-1] = 1'b0;
      end
   endfunction

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   localparam int NSYNC = NPORTS + 7;
   // Overcurrent bits reset to their idle high level, so no false fault follows reset.
   logic [NSYNC-1:0] pin_meta_r;
   logic [NSYNC-1:0] pin_sync_r;
   logic [NSYNC-1:0] pin_raw;

   assign pin_raw = {overcurrent_in_n, bus_power_select, clock_mode, port_count_strap,
                     fixed_port_strap, ext_memory_disable, prom_data_line};

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pin_meta_r <= {{NPORTS{1'b1}}, 7'h00};
         pin_sync_r <= {{NPORTS{1'b1}}, 7'h00};
      end else begin
         pin_meta_r <= pin_raw;
         pin_sync_r <= pin_meta_r;
      end
   end

   logic [NPORTS-1:0] oc_s;
   logic              bus_power_select_s;
   logic              mode_s;
   logic              np_s;
   logic [1:0]        fixed_s;
   logic              extdis_s;
   logic              prom_s;

   assign oc_s     = ~pin_sync_r[NSYNC-1 -: NPORTS];
   assign bus_power_select_s = pin_sync_r[6];
   assign mode_s   = pin_sync_r[5];
   assign np_s     = pin_sync_r[4];
   assign fixed_s  = pin_sync_r[3:2];
   assign extdis_s = pin_sync_r[1];
   assign prom_s   = pin_sync_r[0];

   // ----------------------------------------------------------------
   // Strap capture
   // ----------------------------------------------------------------
   // Straps are caught once the synchronisers have filled, so a
   // strap never feeds an asynchronous reset value.
   logic [1:0] strap_wait_r;
   logic       strap_done_r;
   logic       np_r;
   logic [1:0] fixed_r;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         strap_wait_r <= 2'h0;
         strap_done_r <= 1'b0;
         np_r         <= 1'b0;
         fixed_r      <= 2'h0;
      end else if (!strap_done_r) begin
         strap_wait_r <= strap_wait_r + 2'h1;
         if (strap_wait_r == 2'h2) begin
            strap_done_r <= 1'b1;
            np_r         <= np_s;
            fixed_r      <= fixed_s;
         end
      end
   end

   // ----------------------------------------------------------------
   // Overcurrent filter
   // ----------------------------------------------------------------
   localparam int FW = $clog2(HPC_OC_FILTER_CYC + 1);
   localparam logic [FW-1:0] FILT_LAST = FW'(HPC_OC_FILTER_CYC - 1);

   logic [NPORTS-1:0] oc_filt_r;

   generate
      for (genvar i = 0; i < NPORTS; i++) begin : g_filt
         logic [FW-1:0] cnt_r;
         always_ff @(posedge clock or negedge rst_n) begin
            if (!rst_n) begin
               cnt_r        <= '0;
               oc_filt_r[i] <= 1'b0;
            end else if (oc_s[i] == oc_filt_r[i]) begin
               cnt_r <= '0;
            end else if (cnt_r == FILT_LAST) begin
               cnt_r        <= '0;
               oc_filt_r[i] <= oc_s[i];
            end else begin
               cnt_r <= cnt_r + FW'(1);
            end
         end
         a_oc_filter_hold: assert property (@(posedge clock) disable iff (!rst_n)
            $rose(oc_filt_r[i]) |-> $past(oc_s[i], 1) && $past(oc_s[i], 2) && $past(oc_s[i], 3))
            else $error("Overcurrent passed the filter without being stable.");
      end
   endgenerate

   // ----------------------------------------------------------------
   // Registers written by software
   // ----------------------------------------------------------------
   logic [NPORTS-1:0] req_r;
   logic              shared_cfg_r;
   logic              suspend_req_r;
   logic [NPORTS-1:0] fault_clr;
   logic              wr_ctrl;

   assign wr_ctrl   = reg_write && reg_addr == HPC_OFF_CTRL;
   assign fault_clr = (reg_write && reg_addr == HPC_OFF_FAULT) ? reg_wdata[NPORTS-1:0] : '0;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         req_r         <= NPORTS'(HPC_REQ_RST);
         shared_cfg_r  <= HPC_SHARED_RST;
         suspend_req_r <= 1'b0;
      end else if (wr_ctrl) begin
         req_r         <= reg_wdata[HPC_CTRL_REQ_LSB +: NPORTS];
         shared_cfg_r  <= reg_wdata[HPC_CTRL_SHARED];
         suspend_req_r <= reg_wdata[HPC_CTRL_SUSPEND];
      end
   end

   // ----------------------------------------------------------------
   // Power mode and port power
   // ----------------------------------------------------------------
   logic              shared_r;
   logic              self_pwr_r;
   logic [NPORTS-1:0] fault_r;
   logic [NPORTS-1:0] fault_nxt;
   logic [NPORTS-1:0] fault_set;
   logic [NPORTS-1:0] en_nxt;
   logic [NPORTS-1:0] act;

   assign act = active_ports(!np_r);

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         shared_r   <= 1'b0;
         self_pwr_r <= 1'b0;
      end else begin
         shared_r   <= extdis_s ? prom_s : shared_cfg_r;
         self_pwr_r <= ~bus_power_select_s;
      end
   end

   always_comb begin
      if (shared_r) begin
         fault_set = {NPORTS{|(oc_filt_r & act)}};
      end else begin
         fault_set = oc_filt_r;
      end
      fault_nxt = (fault_r & ~fault_clr) | fault_set;
      if (shared_r) begin
         en_nxt = {NPORTS{req_r[0] && !(|fault_nxt)}} & act;
      end else begin
         en_nxt = req_r & ~fault_nxt & act;
      end
   end

   // A port stays off after an overcurrent until software clears its
   // fault, so a bouncing switch cannot cycle power by itself.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         fault_r           <= '0;
         port_power_enable <= '0;
      end else begin
         fault_r           <= fault_nxt;
         port_power_enable <= en_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Clock source, slew and suspend
   // ----------------------------------------------------------------
   // The clock mux itself sits in the analog ring; this block only
   // drives its select, the power-down controls and the multiplier ratio.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         core_clk_from_mult     <= 1'b1;
         clock_multiplier_pd    <= 1'b0;
         osc_cell_pd            <= 1'b0;
         clock_multiplier_ratio <= HPC_MULT_RATIO;
      end else begin
         core_clk_from_mult     <= ~mode_s;
         clock_multiplier_pd    <= mode_s;
         osc_cell_pd            <= mode_s;
         clock_multiplier_ratio <= HPC_MULT_RATIO;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         port_slew_slow <= '0;
         suspend_status <= 1'b0;
      end else begin
         port_slew_slow <= port_low_speed;
         suspend_status <= suspend_req_r;
      end
   end

   // ----------------------------------------------------------------
   // Descriptor fields
   // ----------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         device_removable <= HPC_REM_NONE;
         hub_compound     <= 1'b0;
         hub_three_port   <= 1'b1;
      end else begin
         device_removable <= removable_field(fixed_r, np_r);
         hub_compound     <= fixed_r != 2'h0;
         hub_three_port   <= !np_r;
      end
   end

   // ----------------------------------------------------------------
   // Register read
   // ----------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= '0;
      end else begin
         reg_rdata <= '0;
         if (reg_read) begin
            case (reg_addr)
               HPC_OFF_CTRL: begin
                  reg_rdata[HPC_CTRL_REQ_LSB +: NPORTS] <= req_r;
                  reg_rdata[HPC_CTRL_SHARED]            <= shared_cfg_r;
                  reg_rdata[HPC_CTRL_SUSPEND]           <= suspend_req_r;
               end
               HPC_OFF_FAULT: reg_rdata[NPORTS-1:0] <= fault_r;
               HPC_OFF_STATUS: begin
                  reg_rdata[HPC_ST_EN_LSB +: NPORTS]   <= port_power_enable;
                  reg_rdata[HPC_ST_OC_LSB +: NPORTS]   <= oc_filt_r;
                  reg_rdata[HPC_ST_SHARED]             <= shared_r;
                  reg_rdata[HPC_ST_BUS_POWER_SELECT]             <= !self_pwr_r;
                  reg_rdata[HPC_ST_CLKMODE]            <= clock_multiplier_pd;
                  reg_rdata[HPC_ST_SLEW_LSB +: NPORTS] <= port_slew_slow;
               end
               HPC_OFF_DESC: begin
                  reg_rdata[7:0]               <= removable_field(fixed_r, np_r);
                  reg_rdata[HPC_DESC_COMPOUND] <= fixed_r != 2'h0;
                  reg_rdata[HPC_DESC_THREE]    <= !np_r;
               end
               default: reg_rdata <= '0;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   generate
      for (genvar p = 0; p < NPORTS; p++) begin : g_chk
         a_oc_power_off: assert property (@(posedge clock) disable iff (!rst_n)
            oc_filt_r[p] && !shared_r |=> !port_power_enable[p])
            else $error("Port stayed powered during overcurrent.");
         a_indep_port_on: assert property (@(posedge clock) disable iff (!rst_n)
            !shared_r && req_r[p] && act[p] && !fault_nxt[p] |=> port_power_enable[p])
            else $error("Port power disturbed by another port.");
      end
   endgenerate
   a_ganged_any_oc: assert property (@(posedge clock) disable iff (!rst_n)
      shared_r && |(oc_filt_r & act) |=> port_power_enable == '0)
      else $error("Shared ports stayed on after an overcurrent.");
   a_ganged_equal: assert property (@(posedge clock) disable iff (!rst_n)
      shared_r && $past(shared_r) |-> port_power_enable == '0 || port_power_enable == act)
      else $error("Shared power enables differ.");
   a_power_mode: assert property (@(posedge clock) disable iff (!rst_n)
      $changed(bus_power_select_s) |=> self_pwr_r == !$past(bus_power_select_s))
      else $error("Power source mode not followed.");
   a_mult_select: assert property (@(posedge clock) disable iff (!rst_n)
      !mode_s |=> core_clk_from_mult && !clock_multiplier_pd && !osc_cell_pd)
      else $error("Multiplier not selected in reference mode.");
   a_mult_bypass: assert property (@(posedge clock) disable iff (!rst_n)
      mode_s |=> !core_clk_from_mult && clock_multiplier_pd && osc_cell_pd)
      else $error("Multiplier not bypassed in direct mode.");
   a_slew_follow: assert property (@(posedge clock) disable iff (!rst_n)
      ##1 port_slew_slow == $past(port_low_speed))
      else $error("Slew rate does not follow port speed.");
   a_port_count: assert property (@(posedge clock) disable iff (!rst_n)
      strap_done_r ##1 1'b1 |-> hub_three_port == !np_r && (!np_r || !port_power_enable[NPORTS-1]))
      else $error("Port count strap not honoured.");
   a_removable: assert property (@(posedge clock) disable iff (!rst_n)
      strap_done_r && fixed_r == 2'h3 ##1 1'b1 |-> device_removable == (np_r ? 8'h06 : 8'h0e))
      else $error("Removable field wrong for all ports fixed.");
   a_compound_bit: assert property (@(posedge clock) disable iff (!rst_n)
      strap_done_r ##1 1'b1 |-> hub_compound == (fixed_r != 2'h0) && (hub_compound || device_removable == 8'h00))
      else $error("Compound bit disagrees with fixed port strap.");
   a_shared_source: assert property (@(posedge clock) disable iff (!rst_n)
      extdis_s |=> shared_r == $past(prom_s))
      else $error("Shared select not taken from the data pin.");
endmodule // hpc_port_power

// File: sim/hpc_switch_model.sv
// Purpose: Behavioural downstream power switches with overcurrent flags.
// Assumes: The bench raises load_fault to short the load of a port.
// Notes:   A flag shows only while its switch is on, as a real switch does.
`timescale 1ns/1ps
module hpc_switch_model #(
   parameter int NPORTS = 3
) (
   // Hub side
   input  wire logic              clock,
   input  wire logic [NPORTS-1:0] port_power_enable,
   input  wire logic              suspend_status,
   // Fault injection
   input  wire logic [NPORTS-1:0] load_fault,
   // Flags and reference
   output logic      [NPORTS-1:0] overcurrent_in_n,
   output logic                   ref_osc
);
   // Open-drain flags with pull-ups sit high unless a powered load is shorted.
   assign overcurrent_in_n = ~(load_fault & port_power_enable);
   // A logic-level reference stand-in; it parks low while the hub is suspended.
   always_ff @(posedge clock) begin
      ref_osc <= suspend_status ? 1'b0 : (ref_osc !== 1'b1);
   end
endmodule // hpc_switch_model

// File: sim/hpc_port_power_tb_top.sv
// Purpose: Self-checking bench for the hub port power and clock block.
// Assumes: Straps are sampled only after a reset, so each strap set gets one.
// Notes:   Expectations come from bench functions, never from the design.
`timescale 1ns/1ps
module hpc_port_power_tb_top;
   import hpc_pkg::*;
   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   logic        clock = 1'b0;
   logic        rst_n = 1'b0;
   logic [7:0]  reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic        reg_write = 1'b0;
   logic        reg_read = 1'b0;
   logic [31:0] reg_rdata, rd;
   logic [2:0]  oc_n, pwr_en, slew, low_spd = 3'h0, load_fault = 3'h0;
   logic        bus_pwr = 1'b0, cm = 1'b0, np = 1'b0, ext_dis = 1'b0, prom = 1'b0;
   logic [1:0]  fp = 2'h0;
   logic        from_mult, mult_pd, osc_pd, susp, compound, three, sh;
   logic [3:0]  ratio;
   logic [7:0]  removable;
   logic [4:0]  ctrl;
   int          err_total = 0, compares = 0, cycles = 0;
   integer      seed = 32'hf6f4;
   // ----------------------------------------------------------------
   // Design and switch model
   // ----------------------------------------------------------------
   hpc_port_power #(.NPORTS(3)) i_dut (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
      .overcurrent_in_n(oc_n), .port_power_enable(pwr_en), .bus_power_select(bus_pwr),
      .clock_mode(cm), .port_count_strap(np), .fixed_port_strap(fp), .ext_memory_disable(ext_dis),
      .prom_data_line(prom), .port_low_speed(low_spd), .port_slew_slow(slew),
      .core_clk_from_mult(from_mult), .clock_multiplier_pd(mult_pd), .osc_cell_pd(osc_pd),
      .clock_multiplier_ratio(ratio), .suspend_status(susp), .device_removable(removable),
      .hub_compound(compound), .hub_three_port(three));
   hpc_switch_model #(.NPORTS(3)) i_sw (.clock(clock), .port_power_enable(pwr_en),
      .suspend_status(susp), .load_fault(load_fault), .overcurrent_in_n(oc_n), .ref_osc());
   // ----------------------------------------------------------------
   // Clock, watchdog and helpers
   // ----------------------------------------------------------------
   always #2 clock = ~clock;
   // The ceiling is some fifty times the expected run, so only a hang reaches it.
   always @(posedge clock) begin
      cycles++;
      if (cycles == 40000) begin
         err_total++;
         wrap_up();
      end
   end
   task automatic wrap_up;
      $display("compares %0d err_total %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      reg_write <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_write <= 1'b0;
   endtask
   task automatic rdr(input logic [7:0] a);
      @(posedge clock);
      reg_read <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_read <= 1'b0;
      #1 rd = reg_rdata;
   endtask
   task automatic do_reset;
      @(posedge clock);
      rst_n <= 1'b0;
      cyc(2);
      rst_n <= 1'b1;
      cyc(6);
   endtask
   function automatic logic [2:0] exp_en(logic [2:0] req, logic [2:0] flt, logic shr, logic thr);
      logic [2:0] act;
      act = thr ? 3'h7 : 3'h3;
      if (shr)
         return (req[0] && (flt & act) == 3'h0) ? act : 3'h0;
      return req & ~flt & act;
   endfunction
   function automatic logic [9:0] exp_desc(logic n, logic [1:0] f);
      logic [7:0] rem;
      rem = (f == 2'h0) ? 8'h00 : (f == 2'h1) ? 8'h02 : (f == 2'h2 || n) ? 8'h06 : 8'h0e;
      return {~n, f != 2'h0, rem};
   endfunction
   // ----------------------------------------------------------------
   // Sequence
   // ----------------------------------------------------------------
   initial begin
      do_reset();
      chk({from_mult, ratio}, 5'h18);
      for (int i = 0; i < 8; i++) begin
         @(posedge clock);
         {np, fp} <= 3'(i);
         do_reset();
         chk({three, compound, removable}, exp_desc(np, fp));
         rdr(HPC_OFF_DESC);
         chk(rd, {22'h0, exp_desc(np, fp)});
         wr(HPC_OFF_CTRL, 32'h7);
         cyc(3);
         chk(pwr_en, exp_en(3'h7, 3'h0, 1'b0, ~np));
      end
      @(posedge clock);
      np <= 1'b0;
      do_reset();
      // Random pin and control mixes, with no faults, cover the four power modes.
      for (int i = 0; i < 32; i++) begin
         @(posedge clock);
         {cm, bus_pwr, ext_dis, prom, low_spd} <= 7'($random(seed));
         ctrl = 5'($random(seed));
         wr(HPC_OFF_CTRL, {27'h0, ctrl});
         cyc(4);
         sh = ext_dis ? prom : ctrl[3];
         chk({from_mult, mult_pd, osc_pd}, {~cm, cm, cm});
         chk({susp, slew}, {ctrl[4], low_spd});
         chk(pwr_en, exp_en(ctrl[2:0], 3'h0, sh, 1'b1));
         rdr(HPC_OFF_STATUS);
         chk(rd[11:0], {low_spd, cm, bus_pwr, sh, 3'h0, exp_en(ctrl[2:0], 3'h0, sh, 1'b1)});
         rdr(HPC_OFF_CTRL);
         chk(rd & 32'h1f, {27'h0, ctrl});
      end
      cyc(1);
      #1 chk(reg_rdata, 32'h0);
      wr(8'h14, 32'hffffffff);
      rdr(8'h10);
      chk(rd, 32'h0);
      // Individual mode: a short glitch is ignored, a long fault drops one port.
      @(posedge clock);
      ext_dis <= 1'b0;
      wr(HPC_OFF_CTRL, 32'h7);
      cyc(4);
      load_fault <= 3'h1;
      cyc(10);
      load_fault <= 3'h0;
      cyc(40);
      chk(pwr_en, 3'h7);
      rdr(HPC_OFF_FAULT);
      chk(rd, 32'h0);
      load_fault <= 3'h2;
      cyc(40);
      chk(pwr_en, exp_en(3'h7, 3'h2, 1'b0, 1'b1));
      rdr(HPC_OFF_FAULT);
      chk(rd, 32'h2);
      load_fault <= 3'h0;
      cyc(40);
      chk(pwr_en, 3'h5);
      wr(HPC_OFF_FAULT, 32'h2);
      cyc(4);
      chk(pwr_en, 3'h7);
      // Shared mode: a fault on the last port turns every port off.
      wr(HPC_OFF_CTRL, 32'h9);
      cyc(4);
      chk(pwr_en, 3'h7);
      load_fault <= 3'h4;
      cyc(40);
      chk(pwr_en, exp_en(3'h1, 3'h4, 1'b1, 1'b1));
      load_fault <= 3'h0;
      cyc(40);
      wr(HPC_OFF_FAULT, 32'h7);
      cyc(4);
      chk(pwr_en, 3'h7);
      wrap_up();
   end
endmodule // hpc_port_power_tb_top
